/* shared/dbs_pkg.sv */
// Shared constants, types and command codes for the breakpoint and status block.
// Assumes the serial link layer outside delivers whole decoded commands.
package dbs_pkg;

    // ==========================================================
    // Widths
    localparam int ADDR_W = 16;
    localparam int BYTE_W = 8;

    // ==========================================================
    // Status and control field positions
    localparam int BIT_PERMIT = 7;
    localparam int BIT_ACTIVE = 6;
    localparam int BIT_BKPT_EN = 5;
    localparam int BIT_FORCE_TAG = 4;
    localparam int BIT_CLKSEL = 3;
    localparam int BIT_WAIT_STOP = 2;
    localparam int BIT_WAIT_FAIL = 1;
    localparam int BIT_DATA_FAIL = 0;

    // ==========================================================
    // Register indices and reset values
    localparam logic [7:0] OFS_SCR = 8'h00;
    localparam logic [7:0] OFS_BKPT_LOW = 8'h02;
    localparam logic [BYTE_W-1:0] SCR_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] BKPT_RESET = 16'h0000;
    localparam logic CLKSEL_ALT = 1'b0;

    // ==========================================================
    // Decoded debug commands
    typedef enum logic [2:0] {
        CMD_READ_STATUS = 3'h0,
        CMD_WRITE_CONTROL = 3'h1,
        CMD_BREAKPOINT_READ_CMD = 3'h2,
        CMD_BREAKPOINT_WRITE_CMD = 3'h3,
        CMD_BACKGROUND = 3'h4,
        CMD_GO = 3'h5,
        CMD_MEM_ACCESS = 3'h6,
        CMD_ACTIVE_ONLY = 3'h7
    } dbs_cmd_e_t;

    // Operating mode, one-hot
    typedef enum logic [1:0] {
        MODE_RUN = 2'b01,
        MODE_ACTIVE = 2'b10
    } dbs_mode_t;

    typedef struct packed {
        dbs_cmd_e_t code;
        logic [ADDR_W-1:0] data;
    } dbs_cmd_t;

    typedef struct packed {
        logic ok;
        logic [ADDR_W-1:0] data;
    } dbs_rsp_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic addr_valid;
        logic fetch;
        logic boundary;
        logic tag_exec;
        logic wait_stop;
        logic slow_busy;
    } dbs_cpu_t;

endpackage

/* hdl/dbs_bkpt_match.sv */
// Breakpoint comparator with tag and force handling.
// Assumes CPU status arrives on the same clock as this block.
`timescale 1ns/100ps
module dbs_bkpt_match #(
    parameter int ADDR_W = dbs_pkg::ADDR_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] bkpt_addr,
    input wire logic bkpt_en,
    input wire logic force_tag_select,
    input wire dbs_pkg::dbs_cpu_t cpu,
    output logic op_tag,
    output logic trigger
);

    // ==========================================================
    // Address compare
    logic match;
    logic force_pend;

    // Full address, high byte above low byte
    assign match = bkpt_en && cpu.addr_valid && (cpu.addr == bkpt_addr);

    // ==========================================================
    // Tag path
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            op_tag <= 1'b0;
        end else begin
            op_tag <= match && !force_tag_select && cpu.fetch;
        end
    end

    // ==========================================================
    // Force path: hold the match until the next boundary
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            force_pend <= 1'b0;
        end else if (!bkpt_en || cpu.boundary) begin
            force_pend <= 1'b0;
        end else if (match && force_tag_select) begin
            force_pend <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trigger <= 1'b0;
        end else if (!bkpt_en) begin
            trigger <= 1'b0;
        end else if (force_tag_select) begin
            trigger <= cpu.boundary && (force_pend || match);
        end else begin
            trigger <= cpu.tag_exec;
        end
    end

endmodule

/* hdl/dbs_top.sv */
// Breakpoint, clock select and status part of the serial debug controller.
// Assumes a link layer that hands over decoded commands one at a time,
// and a CPU that reports address, fetch, boundary and wait/stop state.
//
// What this block does
// - With tag mode the fetched opcode at the breakpoint is tagged and entry happens on its execution.
// - With force mode a match enters background at the next instruction boundary.
// - The clock select bit at bit 3 resets to 0 for the alternate clock and 1 picks the bus clock.
// - In wait or stop a memory access fails outside background mode, but the background command brings the CPU into debug mode.
// - The wait/stop flag at bit 2 is 1 in wait or stop or after background was entered from there.
// - The wait/stop failure flag at bit 1 is set when a memory access fails on wait or stop.
// - The data-valid failure flag at bit 0 is set when a memory access meets an unfinished slow access.
// - The breakpoint address sits in a high and a low byte register, the low one holding bits 7..0.
// - Breakpoint enable and force/tag select live in the status and control register.
// - Breakpoint registers are reached only through the breakpoint read and write commands.
// - Breakpoint read and write work in the foreground while the user program runs.
// - With breakpoint enable clear, force/tag select and the address are ignored.
// - The active flag is read-only, 1 in background mode and 0 while the user program runs.
`timescale 1ns/100ps
module dbs_top #(
    parameter logic [dbs_pkg::ADDR_W-1:0] BKPT_INIT = dbs_pkg::BKPT_RESET
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire dbs_pkg::dbs_cmd_t cmd,
    output logic rsp_valid,
    output dbs_pkg::dbs_rsp_t rsp,
    input wire dbs_pkg::dbs_cpu_t cpu,
    output logic op_tag,
    output logic bgnd_req,
    output logic mem_grant,
    output logic debug_active_flag,
    output logic debug_clock_select
);

    // ==========================================================
    // Control and status state
    dbs_pkg::dbs_mode_t mode;
    logic debug_permit;
    logic breakpoint_enable;
    logic force_tag_select;
    logic wait_stop_hold;
    logic wait_stop_fail_flag;
    logic data_valid_fail_flag;
    logic wait_stop_flag;
    logic [dbs_pkg::BYTE_W-1:0] breakpoint_address_high;
    logic [dbs_pkg::BYTE_W-1:0] breakpoint_address_low;
    logic [dbs_pkg::ADDR_W-1:0] breakpoint_address_pair;
    logic [dbs_pkg::BYTE_W-1:0] debug_status_control;
    logic bkpt_trigger;
    logic bkpt_tag;

    // ==========================================================
    // Command decode
    logic is_active;
    logic cmd_status;
    logic cmd_control;
    logic cmd_bkpt_rd;
    logic cmd_bkpt_wr;
    logic cmd_bgnd;
    logic cmd_go;
    logic cmd_mem;
    logic cmd_act_only;
    logic mem_ws_fail;
    logic mem_dv_fail;
    logic mem_ok;
    logic enter_now;
    logic leave_now;
    logic next_ok;

    assign is_active = (mode == dbs_pkg::MODE_ACTIVE);
    assign cmd_status = cmd_valid && (cmd.code == dbs_pkg::CMD_READ_STATUS);
    assign cmd_control = cmd_valid && (cmd.code == dbs_pkg::CMD_WRITE_CONTROL);
    assign cmd_bkpt_rd = cmd_valid && (cmd.code == dbs_pkg::CMD_BREAKPOINT_READ_CMD);
    assign cmd_bkpt_wr = cmd_valid && (cmd.code == dbs_pkg::CMD_BREAKPOINT_WRITE_CMD);
    assign cmd_bgnd = cmd_valid && (cmd.code == dbs_pkg::CMD_BACKGROUND);
    assign cmd_go = cmd_valid && (cmd.code == dbs_pkg::CMD_GO);
    assign cmd_mem = cmd_valid && (cmd.code == dbs_pkg::CMD_MEM_ACCESS);
    assign cmd_act_only = cmd_valid && (cmd.code == dbs_pkg::CMD_ACTIVE_ONLY);

    // Memory access loses against a CPU parked in wait/stop
    assign mem_ws_fail = cmd_mem && !is_active && cpu.wait_stop;
    // Slow access still running in the CPU
    assign mem_dv_fail = cmd_mem && !mem_ws_fail && cpu.slow_busy;
    assign mem_ok = cmd_mem && !mem_ws_fail && !cpu.slow_busy;

    // Entry needs the permit bit; background works even from wait/stop
    assign enter_now = !is_active && debug_permit && (cmd_bgnd || bkpt_trigger);
    assign leave_now = is_active && cmd_go;

    // ==========================================================
    // Breakpoint address pair, high over low
    assign breakpoint_address_pair = {breakpoint_address_high, breakpoint_address_low};

    dbs_bkpt_match #(
        .ADDR_W(dbs_pkg::ADDR_W)
    ) u_match (
        .clk(clk),
        .sys_rst(sys_rst),
        .bkpt_addr(breakpoint_address_pair),
        .bkpt_en(breakpoint_enable),
        .force_tag_select(force_tag_select),
        .cpu(cpu),
        .op_tag(bkpt_tag),
        .trigger(bkpt_trigger)
    );

    // ==========================================================
    // Mode machine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode <= dbs_pkg::MODE_RUN;
        end else begin
            unique case (mode)
                dbs_pkg::MODE_RUN: begin
                    if (enter_now) begin
                        mode <= dbs_pkg::MODE_ACTIVE;
                    end
                end
                dbs_pkg::MODE_ACTIVE: begin
                    if (cmd_go) begin
                        mode <= dbs_pkg::MODE_RUN;
                    end
                end
                default: begin
                    mode <= dbs_pkg::MODE_RUN;
                end
            endcase
        end
    end

    // ==========================================================
    // Control bits written by the host
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            debug_permit <= dbs_pkg::SCR_RESET[dbs_pkg::BIT_PERMIT];
            breakpoint_enable <= dbs_pkg::SCR_RESET[dbs_pkg::BIT_BKPT_EN];
            force_tag_select <= dbs_pkg::SCR_RESET[dbs_pkg::BIT_FORCE_TAG];
            debug_clock_select <= dbs_pkg::CLKSEL_ALT;
        end else if (cmd_control) begin
            debug_permit <= cmd.data[dbs_pkg::BIT_PERMIT];
            breakpoint_enable <= cmd.data[dbs_pkg::BIT_BKPT_EN];
            force_tag_select <= cmd.data[dbs_pkg::BIT_FORCE_TAG];
            debug_clock_select <= cmd.data[dbs_pkg::BIT_CLKSEL];
        end
    end

    // ==========================================================
    // Breakpoint address, foreground access only by command
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            breakpoint_address_high <= BKPT_INIT[dbs_pkg::ADDR_W-1:dbs_pkg::BYTE_W];
            breakpoint_address_low <= BKPT_INIT[dbs_pkg::BYTE_W-1:0];
        end else if (cmd_bkpt_wr) begin
            breakpoint_address_high <= cmd.data[dbs_pkg::ADDR_W-1:dbs_pkg::BYTE_W];
            breakpoint_address_low <= cmd.data[dbs_pkg::BYTE_W-1:0];
        end
    end

    // ==========================================================
    // Wait/stop tracking
    // Remembers that background was entered out of wait/stop
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wait_stop_hold <= 1'b0;
        end else if (enter_now && cmd_bgnd && cpu.wait_stop) begin
            wait_stop_hold <= 1'b1;
        end else if (leave_now) begin
            wait_stop_hold <= 1'b0;
        end
    end

    assign wait_stop_flag = cpu.wait_stop || wait_stop_hold;

    // ==========================================================
    // Sticky failure flags; a new failure beats the clear
    // Cleared by the next memory access that succeeds.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wait_stop_fail_flag <= 1'b0;
        end else if (mem_ws_fail) begin
            wait_stop_fail_flag <= 1'b1;
        end else if (mem_ok) begin
            wait_stop_fail_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_valid_fail_flag <= 1'b0;
        end else if (mem_dv_fail) begin
            data_valid_fail_flag <= 1'b1;
        end else if (mem_ok) begin
            data_valid_fail_flag <= 1'b0;
        end
    end

    // ==========================================================
    // Status image
    always_comb begin
        debug_status_control = dbs_pkg::SCR_RESET;
        debug_status_control[dbs_pkg::BIT_PERMIT] = debug_permit;
        debug_status_control[dbs_pkg::BIT_ACTIVE] = is_active;
        debug_status_control[dbs_pkg::BIT_BKPT_EN] = breakpoint_enable;
        debug_status_control[dbs_pkg::BIT_FORCE_TAG] = force_tag_select;
        debug_status_control[dbs_pkg::BIT_CLKSEL] = debug_clock_select;
        debug_status_control[dbs_pkg::BIT_WAIT_STOP] = wait_stop_flag;
        debug_status_control[dbs_pkg::BIT_WAIT_FAIL] = wait_stop_fail_flag;
        debug_status_control[dbs_pkg::BIT_DATA_FAIL] = data_valid_fail_flag;
    end

    // ==========================================================
    // Command acceptance
    // Status, control and breakpoint commands always work; background needs the permit bit; memory access needs a free CPU
    always_comb begin
        next_ok = 1'b0;
        if (cmd_status || cmd_control) begin
            next_ok = 1'b1;
        end else if (cmd_bkpt_rd || cmd_bkpt_wr) begin
            next_ok = 1'b1;
        end else if (cmd_bgnd) begin
            next_ok = debug_permit;
        end else if (cmd_go || cmd_act_only) begin
            next_ok = is_active;
        end else if (cmd_mem) begin
            next_ok = mem_ok;
        end
    end

    // ==========================================================
    // Answer, one cycle after the command
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else begin
            rsp_valid <= cmd_valid;
            rsp.ok <= next_ok;
            if (cmd_status) begin
                // Active flag is seen here by the host after entry
                rsp.data <= {{dbs_pkg::BYTE_W{1'b0}}, debug_status_control};
            end else if (cmd_bkpt_rd) begin
                rsp.data <= breakpoint_address_pair;
            end else begin
                rsp.data <= '0;
            end
        end
    end

    // ==========================================================
    // CPU-facing strobes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bgnd_req <= 1'b0;
            mem_grant <= 1'b0;
            op_tag <= 1'b0;
        end else begin
            bgnd_req <= enter_now;
            mem_grant <= mem_ok;
            // Tag is dropped when the permit bit is off, no entry possible
            op_tag <= bkpt_tag && debug_permit;
        end
    end

    // Active flag as a flop so the pin matches the status bit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            debug_active_flag <= 1'b0;
        end else if (enter_now) begin
            debug_active_flag <= 1'b1;
        end else if (leave_now) begin
            debug_active_flag <= 1'b0;
        end
    end

endmodule

/* bench/dbs_top_properties.sv */
// Assertion checker for dbs_top, bound at the foot of this file.
// Sees only top ports; control bits are shadowed from commands.
`timescale 1ns/100ps
module dbs_top_chk #(
    parameter logic [dbs_pkg::ADDR_W-1:0] BKPT_INIT = dbs_pkg::BKPT_RESET
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire dbs_pkg::dbs_cmd_t cmd,
    input wire logic rsp_valid,
    input wire dbs_pkg::dbs_rsp_t rsp,
    input wire dbs_pkg::dbs_cpu_t cpu,
    input wire logic op_tag,
    input wire logic bgnd_req,
    input wire logic mem_grant,
    input wire logic debug_active_flag,
    input wire logic debug_clock_select
);
    // ==========================================
    // Shadow state, updated on the same edge as the block
    logic permit;
    logic bk_en;
    logic force_sel;
    logic [15:0] bkpt;
    logic ctl;
    logic hit;
    assign ctl = cmd_valid && cmd.code == dbs_pkg::CMD_WRITE_CONTROL;
    assign hit = bk_en && permit && cpu.addr_valid && cpu.addr == bkpt && !debug_active_flag;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            permit <= 1'b0;
            bk_en <= 1'b0;
            force_sel <= 1'b0;
        end else if (ctl) begin
            permit <= cmd.data[7];
            bk_en <= cmd.data[5];
            force_sel <= cmd.data[4];
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bkpt <= BKPT_INIT;
        end else if (cmd_valid && cmd.code == dbs_pkg::CMD_BREAKPOINT_WRITE_CMD) begin
            bkpt <= cmd.data;
        end
    end
    // ==========================================
    // Properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    AST_BKPT_FG: assert property (
        cmd_valid && !debug_active_flag && cmd.code inside
        {dbs_pkg::CMD_BREAKPOINT_READ_CMD, dbs_pkg::CMD_BREAKPOINT_WRITE_CMD} |=> rsp_valid && rsp.ok)
        else $error("breakpoint command refused in run");
    AST_BKPT_RD: assert property (
        cmd_valid && cmd.code == dbs_pkg::CMD_BREAKPOINT_READ_CMD |=> rsp.data == $past(bkpt))
        else $error("breakpoint read differs from written value");
    AST_CLK_SEL: assert property (
        ctl |=> debug_clock_select == $past(cmd.data[3]))
        else $error("clock select does not follow control write");
    AST_STAT_RO: assert property (
        cmd_valid && cmd.code == dbs_pkg::CMD_READ_STATUS
        |=> rsp.data[6] == $past(debug_active_flag) && rsp.data[15:8] == 8'h00)
        else $error("status active bit wrong");
    AST_BG_IN: assert property (
        cmd_valid && cmd.code == dbs_pkg::CMD_BACKGROUND && permit && !debug_active_flag
        |=> bgnd_req && debug_active_flag && rsp.ok)
        else $error("background entry missing");
    AST_GO: assert property (
        cmd_valid && cmd.code == dbs_pkg::CMD_GO && debug_active_flag |=> !debug_active_flag)
        else $error("active flag stays after go");
    AST_FORCE: assert property (
        hit && force_sel && cpu.boundary |-> ##2 bgnd_req)
        else $error("forced entry not at boundary");
    AST_TAG: assert property (
        hit && !force_sel && cpu.fetch |-> ##2 op_tag ##1 !op_tag)
        else $error("opcode tag missing");
    AST_OFF: assert property (
        cpu.fetch && !bk_en |-> ##2 !op_tag)
        else $error("tag while breakpoint disabled");
    AST_WSF: assert property (
        cmd_valid && cmd.code == dbs_pkg::CMD_MEM_ACCESS && cpu.wait_stop
        && !debug_active_flag |=> rsp_valid && !rsp.ok)
        else $error("access in wait not refused");
    AST_DVF: assert property (
        cmd_valid && cmd.code == dbs_pkg::CMD_MEM_ACCESS && cpu.slow_busy |=> !rsp.ok)
        else $error("access during slow cycle not refused");
endmodule

bind dbs_top dbs_top_chk #(.BKPT_INIT(BKPT_INIT)) u_chk (.clk(clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .cpu(cpu),
    .op_tag(op_tag), .bgnd_req(bgnd_req), .mem_grant(mem_grant),
    .debug_active_flag(debug_active_flag), .debug_clock_select(debug_clock_select));

/* bench/dbs_host_model.sv */
// Debug host model: sends decoded commands and takes the answers.
// Assumes the answer strobe comes one cycle after the command strobe.
`timescale 1ns/100ps
module dbs_host_model (
    input wire logic clk,
    output logic cmd_valid,
    output dbs_pkg::dbs_cmd_t cmd,
    input wire logic rsp_valid,
    input wire dbs_pkg::dbs_rsp_t rsp
);
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end
    // ==========================================
    // One command; gap idle cycles model a slow host
    task automatic send(input dbs_pkg::dbs_cmd_e_t c, input logic [15:0] d,
        input int gap, output dbs_pkg::dbs_rsp_t r);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd.code = c;
        cmd.data = d;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        // Idle bus shows junk so stale data is never trusted
        cmd.data = ~d;
        r = rsp_valid ? rsp : 'x;
    endtask
    // ==========================================
    // Background command entry, then confirm the active flag by a status read
    task automatic enter_bg(output logic ok);
        dbs_pkg::dbs_rsp_t r;
        send(dbs_pkg::CMD_BACKGROUND, 16'h0000, 0, r);
        send(dbs_pkg::CMD_READ_STATUS, 16'h0000, 0, r);
        ok = r.data[6];
    endtask
endmodule

/* bench/dbs_top_tb_top.sv */
// Testbench for the breakpoint and status block.
// Assumes the host model drives commands; the bench drives the CPU side.
`timescale 1ns/100ps
module dbs_top_tb_top;
    logic clk;
    logic sys_rst;
    logic cmd_valid;
    dbs_pkg::dbs_cmd_t cmd;
    logic rsp_valid;
    dbs_pkg::dbs_rsp_t rsp;
    dbs_pkg::dbs_cpu_t cpu;
    logic op_tag;
    logic bgnd_req;
    logic mem_grant;
    logic debug_active_flag;
    logic debug_clock_select;
    logic ok;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n_tag = 0;
    int n_bg = 0;
    dbs_pkg::dbs_rsp_t r;

    dbs_top u_dut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
        .rsp_valid(rsp_valid), .rsp(rsp), .cpu(cpu), .op_tag(op_tag), .bgnd_req(bgnd_req),
        .mem_grant(mem_grant), .debug_active_flag(debug_active_flag),
        .debug_clock_select(debug_clock_select));
    dbs_host_model u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd),
        .rsp_valid(rsp_valid), .rsp(rsp));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ==========================================
    // Pulse counters and hang guard
    always @(posedge clk) begin
        cyc++;
        n_tag += (op_tag === 1'b1);
        n_bg += (bgnd_req === 1'b1);
        if (cyc == 3000) begin
            failures++;
            final_report();
        end
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic hs(input dbs_pkg::dbs_cmd_e_t c, input logic [15:0] d);
        u_host.send(c, d, 0, r);
    endtask
    // Bits: addr_valid, fetch, boundary, tag_exec; held one cycle
    task automatic cpu_pulse(input logic [15:0] a, input logic [3:0] f);
        @(posedge clk);
        #1;
        cpu.addr = a;
        {cpu.addr_valid, cpu.fetch, cpu.boundary, cpu.tag_exec} = f;
        @(posedge clk);
        #1;
        cpu.addr = ~a;
        {cpu.addr_valid, cpu.fetch, cpu.boundary, cpu.tag_exec} = 4'h0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset;
        hs(dbs_pkg::CMD_READ_STATUS, 16'h0000);
        chk("status", 16'h0000, r.data);
        chk("clock select", 16'h0000, {15'h0, debug_clock_select});
        hs(dbs_pkg::CMD_WRITE_CONTROL, 16'h0008);
        chk("clock select", 16'h0001, {15'h0, debug_clock_select});
        hs(dbs_pkg::CMD_WRITE_CONTROL, 16'h0000);
        chk("clock select", 16'h0000, {15'h0, debug_clock_select});
    endtask
    task automatic t_bkpt_fg;
        u_host.send(dbs_pkg::CMD_BREAKPOINT_WRITE_CMD, 16'h5AA5, 3, r);
        chk("write ok", 16'h0001, {15'h0, r.ok});
        hs(dbs_pkg::CMD_BREAKPOINT_READ_CMD, 16'h0000);
        chk("bkpt low", 16'h00A5, {8'h00, r.data[7:0]});
        chk("bkpt", 16'h5AA5, r.data);
    endtask
    task automatic t_tag;
        hs(dbs_pkg::CMD_WRITE_CONTROL, 16'h00A0);
        hs(dbs_pkg::CMD_BREAKPOINT_WRITE_CMD, 16'h1234);
        n_tag = 0;
        n_bg = 0;
        cpu_pulse(16'h1334, 4'hC);
        chk("tag high byte", 16'h0000, n_tag[15:0]);
        cpu_pulse(16'h1234, 4'hC);
        chk("tag", 16'h0001, n_tag[15:0]);
        chk("no entry before exec", 16'h0000, n_bg[15:0]);
        cpu_pulse(16'h0000, 4'h1);
        chk("entry on exec", 16'h0001, n_bg[15:0]);
        chk("active", 16'h0001, {15'h0, debug_active_flag});
        hs(dbs_pkg::CMD_GO, 16'h0000);
        chk("run", 16'h0000, {15'h0, debug_active_flag});
    endtask
    task automatic t_force;
        u_host.enter_bg(ok);
        chk("active read", 16'h0001, {15'h0, ok});
        hs(dbs_pkg::CMD_BREAKPOINT_WRITE_CMD, 16'h2001);
        hs(dbs_pkg::CMD_WRITE_CONTROL, 16'h00B0);
        hs(dbs_pkg::CMD_GO, 16'h0000);
        n_bg = 0;
        cpu_pulse(16'h2001, 4'h8);
        cpu_pulse(16'h0000, 4'h2);
        chk("forced entry", 16'h0001, n_bg[15:0]);
        hs(dbs_pkg::CMD_GO, 16'h0000);
        n_bg = 0;
        cpu_pulse(16'h2001, 4'hA);
        chk("forced same cycle", 16'h0001, n_bg[15:0]);
        hs(dbs_pkg::CMD_GO, 16'h0000);
        hs(dbs_pkg::CMD_WRITE_CONTROL, 16'h0090);
        n_bg = 0;
        cpu_pulse(16'h2001, 4'hA);
        chk("disabled force", 16'h0000, n_bg[15:0]);
        hs(dbs_pkg::CMD_WRITE_CONTROL, 16'h0080);
        n_tag = 0;
        cpu_pulse(16'h2001, 4'hC);
        chk("disabled tag", 16'h0000, n_tag[15:0]);
    endtask
    task automatic t_wait;
        cpu.wait_stop = 1'b1;
        hs(dbs_pkg::CMD_ACTIVE_ONLY, 16'h0000);
        chk("refused in wait", 16'h0000, {15'h0, r.ok});
        hs(dbs_pkg::CMD_MEM_ACCESS, 16'h0000);
        chk("access fail", 16'h0000, {15'h0, r.ok});
        hs(dbs_pkg::CMD_READ_STATUS, 16'h0000);
        chk("ws wsf", 16'h0006, r.data & 16'h0006);
        u_host.enter_bg(ok);
        chk("out of wait", 16'h0001, {15'h0, ok});
        cpu.wait_stop = 1'b0;
        hs(dbs_pkg::CMD_MEM_ACCESS, 16'h0000);
        chk("repeat ok", 16'h0001, {15'h0, r.ok});
        chk("grant", 16'h0001, {15'h0, mem_grant});
        hs(dbs_pkg::CMD_READ_STATUS, 16'h0000);
        chk("ws latched", 16'h0004, r.data & 16'h0006);
        hs(dbs_pkg::CMD_GO, 16'h0000);
        hs(dbs_pkg::CMD_READ_STATUS, 16'h0000);
        chk("ws clear", 16'h0000, r.data & 16'h0004);
    endtask
    task automatic t_slow;
        cpu.slow_busy = 1'b1;
        hs(dbs_pkg::CMD_MEM_ACCESS, 16'h0000);
        chk("slow fail", 16'h0000, {15'h0, r.ok});
        chk("no grant", 16'h0000, {15'h0, mem_grant});
        hs(dbs_pkg::CMD_READ_STATUS, 16'h0000);
        chk("dvf set", 16'h0001, r.data & 16'h0001);
        cpu.slow_busy = 1'b0;
        hs(dbs_pkg::CMD_MEM_ACCESS, 16'h0000);
        hs(dbs_pkg::CMD_READ_STATUS, 16'h0000);
        chk("dvf clear", 16'h0000, r.data & 16'h0001);
    endtask
    // Reset in mid-run while active with clock select set
    task automatic t_rerst;
        hs(dbs_pkg::CMD_WRITE_CONTROL, 16'h0088);
        hs(dbs_pkg::CMD_BACKGROUND, 16'h0000);
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        chk("rst active clk", 16'h0000, {14'h0, debug_active_flag, debug_clock_select});
        hs(dbs_pkg::CMD_READ_STATUS, 16'h0000);
        chk("rst status", {8'h00, dbs_pkg::SCR_RESET}, r.data);
        hs(dbs_pkg::CMD_BREAKPOINT_READ_CMD, 16'h0000);
        chk("rst bkpt", dbs_pkg::BKPT_RESET, r.data);
    endtask
    task automatic final_report;
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        cpu = '0;
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_bkpt_fg();
        t_tag();
        t_force();
        t_wait();
        t_slow();
        t_rerst();
        final_report();
    end
endmodule
